/* src/param_map_pkg.sv */
// shared constants for the parameter access map and its host end
package param_map_pkg;
	localparam logic [7:0] FUNC_READ = 8'h03;
	localparam logic [7:0] FUNC_WRITE = 8'h06;
	localparam logic [7:0] EXC_FLAG = 8'h80;
	localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
	localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
	localparam logic [7:0] EXC_ILLEGAL_DATA = 8'h03;
	localparam logic [7:0] EXC_DEVICE_FAULT = 8'h04;
	localparam logic [7:0] BROADCAST_ADDR = 8'h00;
	localparam logic [7:0] STATION_MAX = 8'hF7;
	localparam logic [15:0] PARAM_LO = 16'h0001;
	localparam logic [15:0] PARAM_HI = 16'h0D08;
	localparam logic [15:0] MON_LO = 16'h1E01;
	localparam logic [15:0] MON_HI = 16'h2010;
	localparam logic [15:0] ADDR_CONTROL_MODE = 16'h0001;
	localparam logic [15:0] ADDR_STATION = 16'h0C01;
	localparam logic [15:0] ADDR_LINE_RATE = 16'h0C02;
	localparam logic [15:0] ADDR_FRAME_FORMAT = 16'h0C03;
	localparam logic [15:0] ADDR_PERSIST = 16'h0C04;
	localparam logic [15:0] ADDR_DRIVE_STATE = 16'h1E01;
	localparam logic [15:0] RST_STATION = 16'h0001;
	localparam logic [15:0] RST_LINE_RATE = 16'h0002;
	localparam logic [15:0] RST_FRAME_FORMAT = 16'h0000;
	localparam logic [15:0] RST_PERSIST = 16'h0000;
	localparam logic [15:0] RST_CONTROL_MODE = 16'h0001;
	localparam logic [15:0] LINE_RATE_MAX = 16'h0005;
	localparam logic [15:0] FRAME_FORMAT_MAX = 16'h0003;
	localparam logic [15:0] PERSIST_MAX = 16'h0001;
	localparam logic [1:0] CLASS_STOP_RESTART = 2'h0;
	localparam logic [1:0] CLASS_RUN_RESTART = 2'h1;
	localparam logic [1:0] CLASS_STOP_NOW = 2'h2;
	localparam logic [1:0] CLASS_RUN_NOW = 2'h3;
	localparam int PARAM_WORDS = 256;
	localparam int MON_WORDS = 64;
	localparam logic [4:0] CSR_CTRL = 5'h00;
	localparam logic [4:0] CSR_REQ = 5'h04;
	localparam logic [4:0] CSR_DATA = 5'h08;
	localparam logic [4:0] CSR_STATUS = 5'h0C;
	localparam logic [4:0] CSR_RESULT = 5'h10;
endpackage

/* src/param_link_if.sv */
// request and answer carrier between host controller and drive map
`timescale 1ns/1ps
interface param_link_if;
	logic req_valid;
	logic [7:0] req_station;
	logic [7:0] req_func;
	logic [15:0] req_addr;
	logic [15:0] req_data;
	logic rsp_valid;
	logic [7:0] rsp_func;
	logic [7:0] rsp_code;
	logic [15:0] rsp_addr;
	logic [15:0] rsp_data;
	modport drive(input req_valid, req_station, req_func, req_addr, req_data,
		output rsp_valid, rsp_func, rsp_code, rsp_addr, rsp_data);
	modport host(output req_valid, req_station, req_func, req_addr, req_data,
		input rsp_valid, rsp_func, rsp_code, rsp_addr, rsp_data);
endinterface

/* src/region_decode.sv */
// address region classifier used by the drive map
`timescale 1ns/1ps
module region_decode
	import param_map_pkg::*;
(
	// address in
	input wire logic [15:0] addr,
	// region out
	output logic in_param,
	output logic in_mon,
	output logic [7:0] group,
	output logic [7:0] index
);
	assign group = addr[15:8];
	assign index = addr[7:0];
	assign in_param = (addr >= PARAM_LO) && (addr <= PARAM_HI);
	assign in_mon = (addr >= MON_LO) && (addr <= MON_HI);
endmodule

/* src/drive_param_map.sv */
// drive end: station settings, parameter store and request execution
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
import param_map_pkg::*;

// Notes on behaviour
// - station 0 broadcast, 1-247 individual
// - integrator assigns unique station addresses
// - rate codes 0-5, default 2
// - framing codes 0-3 stop/parity choices
// - host matches rate and framing
// - persist selection commits writes to nonvolatile
// - host avoids persistence for frequent writes
// - damaged nonvolatile memory latches permanent fault
// - parameter region read and write
// - monitor region read only
// - address is group high, index low
// - monitor base 0x1E01, same combining
// - signed values in two's complement
// - unsigned values plain binary
// - fractional values as unit step counts
// - host leaves reserved parameters alone
// - every parameter has one update class
// - errors echo function with bit 7
module drive_param_map #(
	parameter int PARAM_DEPTH = PARAM_WORDS,
	parameter int MON_DEPTH = MON_WORDS
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	// link
	param_link_if.drive link,
	// drive state
	input wire logic drive_running,
	input wire logic nvm_damaged,
	input wire logic [15:0] mon_value [MON_DEPTH],
	// settings out
	output logic [7:0] station_address,
	output logic [2:0] line_rate_select,
	output logic [1:0] frame_format_select,
	output logic persist_writes_select,
	output logic [15:0] control_mode_select,
	// nonvolatile commit strobe with address and data, restart pending and latched fault
	output logic nvm_write,
	output logic [15:0] nvm_addr,
	output logic [15:0] nvm_data,
	output logic restart_pending,
	output logic fault_latched
);
	logic in_param;
	logic in_mon;
	logic [7:0] grp;
	logic [7:0] idx;
	logic [15:0] param_mem [PARAM_DEPTH];
	logic [1:0] param_class [PARAM_DEPTH];
	logic [15:0] rd_param;
	logic [15:0] rd_word;
	logic addressed;
	logic is_bcast;
	logic is_read;
	logic is_write;
	logic [7:0] exc;
	logic do_write;
	logic [7:0] slot;
	logic [1:0] wclass;

	region_decode dec (
		.addr(link.req_addr),
		.in_param(in_param),
		.in_mon(in_mon),
		.group(grp),
		.index(idx)
	);

	////////////////////////////////////////////////////////////////////////
	// broadcast versus own station
	assign is_bcast = link.req_station == BROADCAST_ADDR;
	assign addressed = is_bcast || (link.req_station == station_address);
	assign is_read = link.req_func == FUNC_READ;
	assign is_write = link.req_func == FUNC_WRITE;
	// group folded into a small slot; group 12 lands on its own page
	assign slot = {grp[3:0], idx[3:0]};
	// class by slot, gating writes while running
	assign wclass = param_class[slot];
	assign rd_param = param_mem[slot];

	always_comb begin
		rd_word = 16'h0000;
		unique case (link.req_addr)
			ADDR_STATION: rd_word = {8'h00, station_address};
			ADDR_LINE_RATE: rd_word = {13'h0000, line_rate_select};
			ADDR_FRAME_FORMAT: rd_word = {14'h0000, frame_format_select};
			ADDR_PERSIST: rd_word = {15'h0000, persist_writes_select};
			ADDR_CONTROL_MODE: rd_word = control_mode_select;
			default: begin
				if (in_mon) begin
					rd_word = mon_value[6'(link.req_addr - MON_LO)];
				end else begin
					rd_word = rd_param;
				end
			end
		endcase
	end

	always_comb begin
		exc = 8'h00;
		if (fault_latched) begin
			exc = EXC_DEVICE_FAULT;
		end else if (!is_read && !is_write) begin
			exc = EXC_ILLEGAL_FUNC;
		end else if (!(in_param || (in_mon && is_read))) begin
			exc = EXC_ILLEGAL_ADDR;
		end else if (is_write && !range_ok(link.req_addr, link.req_data)) begin
			exc = EXC_ILLEGAL_DATA;
		end else if (is_write && drive_running && !wclass[0]) begin
			exc = EXC_ILLEGAL_DATA;
		end
	end

	function automatic logic range_ok(input logic [15:0] a, input logic [15:0] d);
		range_ok = 1'b1;
		if (a == ADDR_STATION) range_ok = d <= {8'h00, STATION_MAX};
		if (a == ADDR_LINE_RATE) range_ok = d <= LINE_RATE_MAX;
		if (a == ADDR_FRAME_FORMAT) range_ok = d <= FRAME_FORMAT_MAX;
		if (a == ADDR_PERSIST) range_ok = d <= PERSIST_MAX;
	endfunction

	assign do_write = link.req_valid && addressed && is_write && (exc == 8'h00);

	////////////////////////////////////////////////////////////////////////
	// settings load their reset defaults, then take accepted writes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			station_address <= RST_STATION[7:0];
			line_rate_select <= RST_LINE_RATE[2:0];
			frame_format_select <= RST_FRAME_FORMAT[1:0];
			persist_writes_select <= RST_PERSIST[0];
			control_mode_select <= RST_CONTROL_MODE;
		end else if (clk_en && do_write) begin
			unique case (link.req_addr)
				ADDR_STATION: station_address <= link.req_data[7:0];
				ADDR_LINE_RATE: line_rate_select <= link.req_data[2:0];
				ADDR_FRAME_FORMAT: frame_format_select <= link.req_data[1:0];
				ADDR_PERSIST: persist_writes_select <= link.req_data[0];
				ADDR_CONTROL_MODE: control_mode_select <= link.req_data;
				default: begin
				end
			endcase
		end
	end

	// unit-step counts kept as raw integers
	always_ff @(posedge aclk) begin
		if (clk_en && do_write) begin
			param_mem[slot] <= link.req_data;
		end
	end

	// class table: communication page runs-now, others stop-and-restart
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < PARAM_DEPTH; i++) begin
				param_class[i] <= (i[7:4] == 4'hC) ? CLASS_RUN_NOW : CLASS_STOP_RESTART;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			restart_pending <= 1'b0;
		end else if (clk_en && do_write && !wclass[1]) begin
			restart_pending <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// commit to nonvolatile when selected
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			nvm_write <= 1'b0;
			nvm_addr <= 16'h0000;
			nvm_data <= 16'h0000;
		end else if (clk_en) begin
			nvm_write <= do_write && persist_writes_select;
			if (do_write) begin
				nvm_addr <= link.req_addr;
				nvm_data <= link.req_data;
			end
		end
	end

	// fault sticks; reset cannot clear it
	// the reset branch resolves an unknown power-up value to clear, but keeps a set fault
	always_ff @(posedge aclk) begin
		if (clk_en && nvm_damaged) begin
			fault_latched <= 1'b1;
		end else if (!aresetn) begin
			if (fault_latched) begin
				fault_latched <= 1'b1;
			end else begin
				fault_latched <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			link.rsp_valid <= 1'b0;
			link.rsp_func <= 8'h00;
			link.rsp_code <= 8'h00;
			link.rsp_addr <= 16'h0000;
			link.rsp_data <= 16'h0000;
		end else if (clk_en) begin
			link.rsp_valid <= link.req_valid && addressed && !is_bcast;
			if (link.req_valid && addressed) begin
				link.rsp_addr <= link.req_addr;
				link.rsp_code <= exc;
				link.rsp_func <= (exc != 8'h00) ? (link.req_func | EXC_FLAG) : link.req_func;
				link.rsp_data <= is_write ? link.req_data : rd_word;
			end
		end
	end
endmodule

/* src/host_param_ctrl.sv */
// host end: AXI4-Lite command registers driving link requests
`timescale 1ns/1ps
import param_map_pkg::*;
module host_param_ctrl (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	// axi write
	input wire logic [4:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi read
	input wire logic [4:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// link
	param_link_if.host link
);
	logic [7:0] station;
	logic [7:0] func;
	logic [15:0] addr;
	logic [15:0] data;
	logic busy;
	logic done;
	logic [31:0] result;
	logic [4:0] aw_q;
	logic [31:0] w_q;
	logic aw_have;
	logic w_have;
	logic go;

	assign go = aw_have && w_have && !bvalid;

	////////////////////////////////////////////////////////////////////////
	// write channel: address and data in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			aw_have <= 1'b0;
			w_have <= 1'b0;
			aw_q <= 5'h00;
			w_q <= 32'h0000_0000;
			bvalid <= 1'b0;
			bresp <= 2'h0;
		end else if (clk_en) begin
			if (awvalid && awready) begin
				aw_q <= awaddr;
				aw_have <= 1'b1;
				awready <= 1'b0;
			end
			if (wvalid && wready) begin
				w_q <= wdata;
				w_have <= 1'b1;
				wready <= 1'b0;
			end
			if (go) begin
				bvalid <= 1'b1;
				bresp <= (aw_q == CSR_CTRL || aw_q == CSR_REQ || aw_q == CSR_DATA) ? 2'h0 : 2'h2;
				aw_have <= 1'b0;
				w_have <= 1'b0;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			station <= RST_STATION[7:0];
			func <= FUNC_READ;
			addr <= 16'h0000;
			data <= 16'h0000;
		end else if (clk_en && go) begin
			unique case (aw_q)
				CSR_REQ: begin
					station <= w_q[7:0];
					func <= w_q[15:8];
				end
				CSR_DATA: begin
					addr <= w_q[31:16];
					data <= w_q[15:0];
				end
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// one request on the bus at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy <= 1'b0;
			done <= 1'b0;
			result <= 32'h0000_0000;
			link.req_valid <= 1'b0;
			link.req_station <= 8'h00;
			link.req_func <= 8'h00;
			link.req_addr <= 16'h0000;
			link.req_data <= 16'h0000;
		end else if (clk_en) begin
			link.req_valid <= 1'b0;
			if (go && aw_q == CSR_CTRL && w_q[0] && !busy) begin
				link.req_valid <= 1'b1;
				link.req_station <= station;
				link.req_func <= func;
				link.req_addr <= addr;
				link.req_data <= data;
				busy <= station != BROADCAST_ADDR;
				done <= station == BROADCAST_ADDR;
			end else if (go && aw_q == CSR_CTRL && w_q[1]) begin
				done <= 1'b0;
			end
			if (busy && link.rsp_valid) begin
				busy <= 1'b0;
				done <= 1'b1;
				result <= {link.rsp_code, link.rsp_func, link.rsp_data};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= 2'h0;
		end else if (clk_en) begin
			if (arvalid && arready) begin
				arready <= 1'b0;
				rvalid <= 1'b1;
				rresp <= 2'h0;
				unique case (araddr)
					CSR_REQ: rdata <= {16'h0000, func, station};
					CSR_DATA: rdata <= {addr, data};
					CSR_STATUS: rdata <= {30'h0000_0000, done, busy};
					CSR_RESULT: rdata <= result;
					CSR_CTRL: rdata <= 32'h0000_0000;
					default: begin
						rdata <= 32'h0000_0000;
						rresp <= 2'h2;
					end
				endcase
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end
		end
	end
endmodule

/* bench/param_map_asserts.sv */
// link checks between the host end and the drive end
`timescale 1ns/1ps
module param_map_asserts
	import param_map_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// link
	input wire logic req_valid,
	input wire logic [7:0] req_station,
	input wire logic [7:0] req_func,
	input wire logic [15:0] req_addr,
	input wire logic [15:0] req_data,
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_func,
	input wire logic [7:0] rsp_code,
	input wire logic [15:0] rsp_addr,
	input wire logic [15:0] rsp_data
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic wr, in_mon, mapped, legal;
	assign wr = req_valid && req_func == FUNC_WRITE && req_station != BROADCAST_ADDR;
	assign in_mon = req_addr >= MON_LO && req_addr <= MON_HI;
	assign mapped = (req_addr >= PARAM_LO && req_addr <= PARAM_HI) || in_mon;
	assign legal = req_func == FUNC_READ || req_func == FUNC_WRITE;
	////////////////////////////////////////////////////////////////
	a_no_unasked: assert property (rsp_valid |-> $past(req_valid) && $past(req_station) != BROADCAST_ADDR
		&& $past(req_station) <= STATION_MAX) else $error("answer without addressed request");
	a_err_flagged: assert property (rsp_valid && rsp_code != 8'h00 |-> rsp_func == ($past(req_func) | EXC_FLAG))
		else $error("error answer lacks flag");
	a_ok_echo: assert property (rsp_valid && rsp_code == 8'h00 |-> rsp_func == $past(req_func)
		&& rsp_addr == $past(req_addr)) else $error("answer echo wrong");
	a_write_echo: assert property (rsp_valid && rsp_code == 8'h00 && $past(req_func) == FUNC_WRITE
		|-> rsp_data == $past(req_data)) else $error("write answer data wrong");
	a_mon_readonly: assert property (wr && in_mon |=> !rsp_valid || rsp_code == EXC_ILLEGAL_ADDR
		|| rsp_code == EXC_DEVICE_FAULT) else $error("monitor write not refused");
	a_unmapped_refused: assert property (req_valid && legal && !mapped |=> !rsp_valid
		|| rsp_code == EXC_ILLEGAL_ADDR || rsp_code == EXC_DEVICE_FAULT) else $error("unmapped not refused");
	a_bad_func: assert property (req_valid && !legal |=> !rsp_valid || rsp_code == EXC_ILLEGAL_FUNC
		|| rsp_code == EXC_DEVICE_FAULT) else $error("bad function not refused");
	a_rate_range: assert property (wr && req_addr == ADDR_LINE_RATE && req_data > LINE_RATE_MAX |=> !rsp_valid
		|| rsp_code == EXC_ILLEGAL_DATA || rsp_code == EXC_DEVICE_FAULT) else $error("bad rate accepted");
	a_format_range: assert property (wr && req_addr == ADDR_FRAME_FORMAT && req_data > FRAME_FORMAT_MAX
		|=> !rsp_valid || rsp_code == EXC_ILLEGAL_DATA || rsp_code == EXC_DEVICE_FAULT) else $error("bad format accepted");
	a_station_range: assert property (wr && req_addr == ADDR_STATION && req_data > {8'h00, STATION_MAX}
		|=> !rsp_valid || rsp_code == EXC_ILLEGAL_DATA || rsp_code == EXC_DEVICE_FAULT) else $error("bad station accepted");
	c_ok: cover property (rsp_valid && rsp_code == 8'h00);
	c_refused: cover property (rsp_valid && rsp_code == EXC_ILLEGAL_ADDR);
	c_broadcast: cover property (req_valid && req_station == BROADCAST_ADDR);
endmodule

/* bench/tb.sv */
// self-checking bench: host end commanding the drive end over the link
`timescale 1ns/1ps
module tb;
	import param_map_pkg::*;
	logic aclk = 0, aresetn = 0, running = 0, damaged = 0;
	logic [4:0] awaddr = '0, araddr = '0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = '0;
	logic awready, wready, bvalid, arready, rvalid, nvm_write, restart_pending, fault_latched;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata, res, s;
	logic [15:0] mon [MON_WORDS];
	logic [15:0] nvm_addr, nvm_data, control_mode_select;
	logic [7:0] station_address;
	logic [2:0] line_rate_select;
	logic [1:0] frame_format_select;
	logic persist_writes_select;
	int err_total = 0, comparisons = 0, rsp_seen = 0, nvm_seen = 0, n0;
	always #20 aclk = ~aclk;
	param_link_if link ();
	drive_param_map drive_param_map_i (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .link(link.drive),
		.drive_running(running), .nvm_damaged(damaged), .mon_value(mon), .station_address(station_address),
		.line_rate_select(line_rate_select), .frame_format_select(frame_format_select),
		.persist_writes_select(persist_writes_select), .control_mode_select(control_mode_select),
		.nvm_write(nvm_write), .nvm_addr(nvm_addr), .nvm_data(nvm_data), .restart_pending(restart_pending),
		.fault_latched(fault_latched));
	host_param_ctrl host_param_ctrl_i (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .link(link.host));
	param_map_asserts param_map_asserts_i (.aclk(aclk), .aresetn(aresetn), .req_valid(link.req_valid),
		.req_station(link.req_station), .req_func(link.req_func), .req_addr(link.req_addr),
		.req_data(link.req_data), .rsp_valid(link.rsp_valid), .rsp_func(link.rsp_func),
		.rsp_code(link.rsp_code), .rsp_addr(link.rsp_addr), .rsp_data(link.rsp_data));
	always @(posedge aclk) begin
		if (link.rsp_valid === 1'b1) rsp_seen++;
		if (nvm_write === 1'b1) nvm_seen++;
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic timed_out();
		err_total++;
		$display("Error handshake expected answer seen none");
		give_verdict();
	endtask
	task automatic do_reset();
		@(posedge aclk);
		aresetn <= 0;
		repeat (5) @(posedge aclk);
		aresetn <= 1;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic axi_wr(input logic [4:0] a, input logic [31:0] d);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		for (n = 0; n < 64; n++) begin
			@(posedge aclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
			if (bvalid) break;
		end
		bready <= 0;
		r = bresp;
		if (n == 64) timed_out();
	endtask
	task automatic axi_rd(input logic [4:0] a);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		for (n = 0; n < 64; n++) begin
			@(posedge aclk);
			if (arready) arvalid <= 0;
			if (rvalid) break;
		end
		rready <= 0;
		s = rdata;
		r = rresp;
		if (n == 64) timed_out();
	endtask
	// the host stays busy on a silent request to another station, so only answered stations go through here
	task automatic op(input logic [7:0] st, input logic [7:0] fn, input logic [15:0] ad, input logic [15:0] dt,
		input logic [7:0] code, input logic [15:0] exp);
		int n;
		axi_wr(CSR_REQ, {16'h0000, fn, st});
		axi_wr(CSR_DATA, {ad, dt});
		axi_wr(CSR_CTRL, 32'h00000001);
		for (n = 0; n < 16; n++) begin
			axi_rd(CSR_STATUS);
			if (s[1] === 1'b1) break;
		end
		if (n == 16) timed_out();
		axi_rd(CSR_RESULT);
		res = s;
		axi_wr(CSR_CTRL, 32'h00000002);
		chk("code", {8'h00, code}, {8'h00, res[31:24]});
		chk("func", {8'h00, code != 8'h00 ? fn | EXC_FLAG : fn}, {8'h00, res[23:16]});
		if (code == 8'h00) chk("data", exp, res[15:0]);
	endtask
	function automatic logic [15:0] setting(input logic [15:0] ad);
		case (ad)
			ADDR_LINE_RATE: return {13'h0000, line_rate_select};
			ADDR_FRAME_FORMAT: return {14'h0000, frame_format_select};
			default: return {15'h0000, persist_writes_select};
		endcase
	endfunction
	// every code up to the limit is taken, one past it is refused and leaves the last value
	task automatic sweep(input logic [15:0] ad, input logic [15:0] top);
		for (int v = 0; v <= top + 1; v++) begin
			op(8'h01, FUNC_WRITE, ad, 16'(v), v > top ? EXC_ILLEGAL_DATA : 8'h00, 16'(v));
			chk("setting", v > top ? top : 16'(v), setting(ad));
		end
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk("station", RST_STATION, {8'h00, station_address});
		chk("rate", RST_LINE_RATE, setting(ADDR_LINE_RATE));
		chk("format", RST_FRAME_FORMAT, setting(ADDR_FRAME_FORMAT));
		chk("persist", RST_PERSIST, setting(ADDR_PERSIST));
		chk("mode", RST_CONTROL_MODE, control_mode_select);
		chk("fault", 16'h0000, {15'h0000, fault_latched});
		axi_rd(5'h14);
		chk("unmapped resp", 16'h0002, {14'h0000, r});
		$display("test reset done");
	endtask
	task automatic t_settings();
		sweep(ADDR_LINE_RATE, LINE_RATE_MAX);
		sweep(ADDR_FRAME_FORMAT, FRAME_FORMAT_MAX);
		sweep(ADDR_PERSIST, PERSIST_MAX);
		n0 = nvm_seen;
		op(8'h01, FUNC_WRITE, 16'h010A, 16'h0BB8, 8'h00, 16'h0BB8);
		chk("commits", 16'(n0 + 1), 16'(nvm_seen));
		chk("commit addr", 16'h010A, nvm_addr);
		chk("commit data", 16'h0BB8, nvm_data);
		op(8'h01, FUNC_WRITE, ADDR_PERSIST, 16'h0000, 8'h00, 16'h0000);
		n0 = nvm_seen;
		op(8'h01, FUNC_WRITE, PARAM_HI, 16'h03E8, 8'h00, 16'h03E8);
		chk("commits", 16'(n0), 16'(nvm_seen));
		op(8'h01, FUNC_WRITE, ADDR_STATION, 16'h00F7, 8'h00, 16'h00F7);
		chk("station", 16'h00F7, {8'h00, station_address});
		op(8'hF7, FUNC_WRITE, ADDR_STATION, 16'h00F8, EXC_ILLEGAL_DATA, 16'h0000);
		op(8'hF7, FUNC_WRITE, ADDR_STATION, 16'h0001, 8'h00, 16'h0001);
		$display("test settings done");
	endtask
	task automatic t_regions();
		op(8'h01, FUNC_READ, ADDR_DRIVE_STATE, 16'h0000, 8'h00, mon[0]);
		op(8'h01, FUNC_READ, MON_LO + 16'h003F, 16'h0000, 8'h00, mon[63]);
		op(8'h01, FUNC_WRITE, MON_LO, 16'h1234, EXC_ILLEGAL_ADDR, 16'h0000);
		op(8'h01, FUNC_READ, 16'h0000, 16'h0000, EXC_ILLEGAL_ADDR, 16'h0000);
		op(8'h01, FUNC_READ, PARAM_HI + 16'h0001, 16'h0000, EXC_ILLEGAL_ADDR, 16'h0000);
		op(8'h01, FUNC_WRITE, MON_HI + 16'h0001, 16'h0001, EXC_ILLEGAL_ADDR, 16'h0000);
		op(8'h01, 8'h10, 16'h010A, 16'h0000, EXC_ILLEGAL_FUNC, 16'h0000);
		op(8'h01, FUNC_WRITE, 16'h010A, 16'hFF9C, 8'h00, 16'hFF9C);
		op(8'h01, FUNC_READ, 16'h010A, 16'h0000, 8'h00, 16'hFF9C);
		op(8'h01, FUNC_READ, PARAM_HI, 16'h0000, 8'h00, 16'h03E8);
		op(8'h01, FUNC_WRITE, ADDR_CONTROL_MODE, 16'h0003, 8'h00, 16'h0003);
		chk("mode", 16'h0003, control_mode_select);
		$display("test regions done");
	endtask
	task automatic t_running();
		@(posedge aclk);
		running <= 1;
		op(8'h01, FUNC_WRITE, 16'h010A, 16'h0064, EXC_ILLEGAL_DATA, 16'h0000);
		op(8'h01, FUNC_READ, 16'h010A, 16'h0000, 8'h00, 16'hFF9C);
		op(8'h01, FUNC_WRITE, ADDR_FRAME_FORMAT, 16'h0001, 8'h00, 16'h0001);
		chk("restart", 16'h0001, {15'h0000, restart_pending});
		running <= 0;
		$display("test running done");
	endtask
	task automatic t_broadcast();
		n0 = rsp_seen;
		axi_wr(CSR_REQ, {16'h0000, FUNC_WRITE, BROADCAST_ADDR});
		axi_wr(CSR_DATA, {ADDR_LINE_RATE, 16'h0004});
		axi_wr(CSR_CTRL, 32'h00000001);
		for (int n = 0; n < 20 && line_rate_select !== 3'h4; n++) @(posedge aclk);
		repeat (4) @(posedge aclk);
		chk("rate", 16'h0004, setting(ADDR_LINE_RATE));
		chk("answers", 16'(n0), 16'(rsp_seen));
		$display("test broadcast done");
	endtask
	task automatic t_fault();
		do_reset();
		damaged <= 1;
		op(8'h01, FUNC_READ, ADDR_STATION, 16'h0000, EXC_DEVICE_FAULT, 16'h0000);
		chk("fault", 16'h0001, {15'h0000, fault_latched});
		damaged <= 0;
		do_reset();
		chk("fault", 16'h0001, {15'h0000, fault_latched});
		op(8'h01, FUNC_READ, ADDR_STATION, 16'h0000, EXC_DEVICE_FAULT, 16'h0000);
		$display("test fault done");
	endtask
	initial begin
		for (int k = 0; k < MON_WORDS; k++) mon[k] = 16'h5A00 + 16'(k);
		do_reset();
		t_reset();
		t_settings();
		t_regions();
		t_running();
		t_broadcast();
		t_fault();
		give_verdict();
	end
endmodule
